// file: src/lcc_defs.vh
`ifndef LCC_DEFS_VH
`define LCC_DEFS_VH
`define LCC_ADDR_GEN_CFG   8'h03
`define LCC_ADDR_TMO_CTRL  8'h04
`define LCC_GEN_CFG_RST    8'hF0
`define LCC_TMO_CTRL_RST   8'hFE
`define LCC_RSVD_MASK      8'h81
`define LCC_BIT_RSVD7      7
`define LCC_BIT_CHK_GEN    6
`define LCC_BIT_PULL_SEL   5
`define LCC_BIT_FILT_EN    4
`define LCC_BIT_FORWARD    3
`define LCC_BIT_AUTO_ACK   2
`define LCC_BIT_GATE_VALID 1
`define LCC_BIT_TMO_OFF    0
`define LCC_TMO_MSB        7
`define LCC_TMO_LSB        1
`define LCC_TMO_STEP_MS    2
`define LCC_CLK_MHZ        250
`define LCC_FILT_ONE_LANE  3'h2
`define LCC_FILT_TWO_LANE  3'h4
`endif

// file: src/lcc_pulse_filter.v
`timescale 1ns/1ps
// rejects pulses shorter than min_len cycles; output follows after a stable run
module lcc_pulse_filter (
  input  wire       CLOCK,
  input  wire       RST_N,
  input  wire       enable,
  input  wire [2:0] min_len,
  input  wire       din,
  output reg        dout
);
  reg [2:0] run_q;
  reg       last_q;

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      run_q  <= 3'h0;
      last_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      last_q <= din;
      if (din != last_q) begin
        run_q <= 3'h1;
      end else if (run_q != 3'h7) begin
        run_q <= run_q + 3'h1;
      end
      if (!enable) begin
        dout <= din;
      end else if (din == last_q && ({1'b0, run_q} + 4'h1) >= {1'b0, min_len}) begin
        dout <= din;
      end
    end
  end
endmodule

// file: src/lcc_top.v
`timescale 1ns/1ps
`include "lcc_defs.vh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - bit 6 set enables back-link check code generation; resets to one
// - bit 5 selects undriven-input pull: one pull-down, zero pull-up; resets one
// - bit 4 rejects short sync/valid pulses: 2 cycles one-lane, 4 two-lane
// - bit 3 forwards address-matched local I2C transactions to remote; resets zero
// - bit 2 acknowledges I2C writes regardless of forward-channel lock
// - protected partner: pixel data always gated by valid; bit 1 ignored
// - plain partner: pixels pass ungated unless bit 1 set
// - watchdog ends control-channel transaction exceeding interval in bits 7..1
// - interval unit is 2 ms; resets to all ones
// - watchdog bit 0 set disables watchdog; resets zero
//////////////////////////////////////////////////////////////////////////////
module lcc_top #(
  parameter PIX_W      = 24,
  parameter CYC_PER_MS = `LCC_CLK_MHZ * 1000
) (
  input  wire             CLOCK,
  input  wire             RST_N,
  input  wire [7:0]       REG_ADDR,
  input  wire             REG_WR,
  input  wire [7:0]       REG_WDATA,
  output reg  [7:0]       REG_RDATA,
  input  wire             TWO_LANE_MODE,
  input  wire             PARTNER_PROTECTED,
  input  wire             LINE_SYNC_IN,
  input  wire             FRAME_SYNC_IN,
  input  wire             DATA_VALID_STROBE_IN,
  input  wire [PIX_W-1:0] PIXEL_IN,
  output reg              LINE_SYNC_OUT,
  output reg              FRAME_SYNC_OUT,
  output reg              DATA_VALID_STROBE_OUT,
  output reg  [PIX_W-1:0] PIXEL_OUT,
  input  wire             I2C_ADDR_MATCH,
  input  wire             I2C_IS_WRITE,
  input  wire             FWD_LOCKED,
  output reg              I2C_FORWARD,
  output reg              I2C_AUTO_ACK,
  input  wire             CTRL_XACT_START,
  input  wire             CTRL_XACT_DONE,
  output reg              CTRL_XACT_ABORT,
  output reg              BACK_LINK_CHECK_GEN_ON,
  output reg              UNDRIVEN_INPUT_PULL_SEL
);
  localparam TMO_W = 32;
  localparam [TMO_W-1:0] STEP_CYC = `LCC_TMO_STEP_MS * CYC_PER_MS;

  reg  [7:0]       gen_cfg_q;
  reg  [7:0]       tmo_ctrl_q;
  reg              wd_busy_q;
  reg  [TMO_W-1:0] wd_cyc_q;
  reg  [6:0]       wd_units_q;
  wire [2:0]       min_len;
  wire             ls_f;
  wire             fs_f;
  wire             dv_f;
  wire             gate_on;
  wire [6:0]       tmo_count;

  //////////////////////////////////////////////////////////////////////////////
  // register file
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      gen_cfg_q  <= `LCC_GEN_CFG_RST;
      tmo_ctrl_q <= `LCC_TMO_CTRL_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == `LCC_ADDR_GEN_CFG) begin
        gen_cfg_q <= REG_WDATA;
      end
      if (REG_ADDR == `LCC_ADDR_TMO_CTRL) begin
        tmo_ctrl_q <= REG_WDATA;
      end
    end
  end

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else begin
      case (REG_ADDR)
        `LCC_ADDR_GEN_CFG:  REG_RDATA <= gen_cfg_q;
        `LCC_ADDR_TMO_CTRL: REG_RDATA <= tmo_ctrl_q;
        default:            REG_RDATA <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // static controls
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      BACK_LINK_CHECK_GEN_ON  <= 1'b1;
      UNDRIVEN_INPUT_PULL_SEL <= 1'b1;
      I2C_FORWARD             <= 1'b0;
      I2C_AUTO_ACK            <= 1'b0;
    end else begin
      BACK_LINK_CHECK_GEN_ON  <= gen_cfg_q[`LCC_BIT_CHK_GEN];
      UNDRIVEN_INPUT_PULL_SEL <= gen_cfg_q[`LCC_BIT_PULL_SEL];
      I2C_FORWARD  <= gen_cfg_q[`LCC_BIT_FORWARD] & I2C_ADDR_MATCH;
      I2C_AUTO_ACK <= I2C_IS_WRITE &
                      (gen_cfg_q[`LCC_BIT_AUTO_ACK] | FWD_LOCKED);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sync and valid filters
  assign min_len = TWO_LANE_MODE ? `LCC_FILT_TWO_LANE : `LCC_FILT_ONE_LANE;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_filt
      wire in_sig;
      wire out_sig;
      assign in_sig = (gi == 0) ? LINE_SYNC_IN :
                      (gi == 1) ? FRAME_SYNC_IN : DATA_VALID_STROBE_IN;
      lcc_pulse_filter u_filt (
        .CLOCK   (CLOCK),
        .RST_N   (RST_N),
        .enable  (gen_cfg_q[`LCC_BIT_FILT_EN]),
        .min_len (min_len),
        .din     (in_sig),
        .dout    (out_sig)
      );
    end
  endgenerate
  assign ls_f = g_filt[0].out_sig;
  assign fs_f = g_filt[1].out_sig;
  assign dv_f = g_filt[2].out_sig;

  //////////////////////////////////////////////////////////////////////////////
  // pixel gating
  assign gate_on = PARTNER_PROTECTED | gen_cfg_q[`LCC_BIT_GATE_VALID];

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      LINE_SYNC_OUT         <= 1'b0;
      FRAME_SYNC_OUT        <= 1'b0;
      DATA_VALID_STROBE_OUT <= 1'b0;
      PIXEL_OUT             <= {PIX_W{1'b0}};
    end else begin
      LINE_SYNC_OUT         <= ls_f;
      FRAME_SYNC_OUT        <= fs_f;
      DATA_VALID_STROBE_OUT <= dv_f;
      PIXEL_OUT             <= (gate_on & ~dv_f) ? {PIX_W{1'b0}} : PIXEL_IN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control channel watchdog
  assign tmo_count = tmo_ctrl_q[`LCC_TMO_MSB:`LCC_TMO_LSB];

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      wd_busy_q       <= 1'b0;
      wd_cyc_q        <= {TMO_W{1'b0}};
      wd_units_q      <= 7'h00;
      CTRL_XACT_ABORT <= 1'b0;
    end else begin
      CTRL_XACT_ABORT <= 1'b0;
      if (CTRL_XACT_START) begin
        wd_busy_q  <= 1'b1;
        wd_cyc_q   <= {TMO_W{1'b0}};
        wd_units_q <= 7'h00;
      end else if (CTRL_XACT_DONE || tmo_ctrl_q[`LCC_BIT_TMO_OFF]) begin
        wd_busy_q  <= 1'b0;
        wd_cyc_q   <= {TMO_W{1'b0}};
        wd_units_q <= 7'h00;
      end else if (wd_busy_q) begin
        if (wd_cyc_q == STEP_CYC - 1) begin
          wd_cyc_q <= {TMO_W{1'b0}};
          if (wd_units_q + 7'h01 >= tmo_count) begin
            wd_busy_q       <= 1'b0;
            wd_units_q      <= 7'h00;
            CTRL_XACT_ABORT <= 1'b1;
          end else begin
            wd_units_q <= wd_units_q + 7'h01;
          end
        end else begin
          wd_cyc_q <= wd_cyc_q + 1'b1;
        end
      end
    end
  end
endmodule

// file: testbench/lcc_partner.sv
`timescale 1ns/1ps
// far side of the control channel: completes after delay cycles, 0 = stalls
module lcc_partner (
  input  wire       clock,
  input  wire       go,
  input  wire [7:0] delay,
  output reg        start,
  output reg        done
);
  reg [7:0] cnt_q = 8'h00;
  initial start = 1'h0;
  initial done = 1'h0;
  always @(posedge clock) begin
    start <= go;
    done <= (cnt_q == 8'h01);
    if (go)
      cnt_q <= delay;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
endmodule

// file: testbench/lcc_assertions.sv
`timescale 1ns/1ps
module lcc_assertions (
  input wire       CLOCK,
  input wire       RST_N,
  input wire [7:0] REG_ADDR,
  input wire       REG_WR,
  input wire [7:0] REG_WDATA,
  input wire       CTRL_XACT_START,
  input wire       CTRL_XACT_DONE,
  input wire       CTRL_XACT_ABORT,
  input wire       BACK_LINK_CHECK_GEN_ON
);
  reg [7:0] t_q;
  always @(posedge CLOCK) begin
    if (!RST_N)
      t_q <= 8'hfe;
    else if (REG_WR && REG_ADDR == 8'h04)
      t_q <= REG_WDATA;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  gen_reset_a: assert property ($rose(RST_N) |-> BACK_LINK_CHECK_GEN_ON) else $error("gen rst");
  gen_write_a: assert property (REG_WR && REG_ADDR == 8'h03 |-> ##2
    BACK_LINK_CHECK_GEN_ON == $past(REG_WDATA[6], 2)) else $error("gen wr");
  gen_hold_a: assert property (!REG_WR |-> ##2 $stable(BACK_LINK_CHECK_GEN_ON))
    else $error("gen hold");
  tmo_fire_a: assert property (CTRL_XACT_START && t_q == 8'h02 ##1
    (!CTRL_XACT_START && !CTRL_XACT_DONE) [*8] |-> ##[1:6] CTRL_XACT_ABORT) else $error("late");
  tmo_early_a: assert property (CTRL_XACT_START && t_q == 8'h02 |=> !CTRL_XACT_ABORT [*8])
    else $error("early");
  tmo_off_a: assert property (t_q[0] && $past(t_q[0]) |-> !CTRL_XACT_ABORT)
    else $error("off");
  done_clr_a: assert property (CTRL_XACT_DONE && !CTRL_XACT_START |-> ##2
    !CTRL_XACT_ABORT [*8]) else $error("done");
  one_abort_a: assert property (CTRL_XACT_ABORT |=> !CTRL_XACT_ABORT [*8]) else $error("twice");
endmodule
bind lcc_top lcc_assertions lcc_assertions_inst (.CLOCK(CLOCK), .RST_N(RST_N),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
  .CTRL_XACT_START(CTRL_XACT_START), .CTRL_XACT_DONE(CTRL_XACT_DONE),
  .CTRL_XACT_ABORT(CTRL_XACT_ABORT), .BACK_LINK_CHECK_GEN_ON(BACK_LINK_CHECK_GEN_ON));

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clock = 0, rst_n = 0, wr = 0, two = 0, prot = 0, sy = 0, mt = 0, iw = 0, go = 0;
  logic        lk = 0, dv = 0;
  logic [7:0]  addr = 0, wd = 0, dly = 0;
  logic [23:0] pix = 0;
  wire  [7:0]  rd;
  wire  [23:0] po;
  wire         ls, fso, dvo, fw, ak, st, dn, ab, cg, pl;
  int          err_count = 0, cmp_count = 0;
  always #2 clock = ~clock;
  lcc_top #(.CYC_PER_MS(5)) lcc_top_inst (.CLOCK(clock), .RST_N(rst_n), .REG_ADDR(addr),
    .REG_WR(wr), .REG_WDATA(wd), .REG_RDATA(rd), .TWO_LANE_MODE(two), .PARTNER_PROTECTED(prot),
    .LINE_SYNC_IN(sy), .FRAME_SYNC_IN(sy), .DATA_VALID_STROBE_IN(dv), .PIXEL_IN(pix),
    .LINE_SYNC_OUT(ls), .FRAME_SYNC_OUT(fso), .DATA_VALID_STROBE_OUT(dvo), .PIXEL_OUT(po),
    .I2C_ADDR_MATCH(mt), .I2C_IS_WRITE(iw), .FWD_LOCKED(lk), .I2C_FORWARD(fw),
    .I2C_AUTO_ACK(ak), .CTRL_XACT_START(st), .CTRL_XACT_DONE(dn), .CTRL_XACT_ABORT(ab),
    .BACK_LINK_CHECK_GEN_ON(cg), .UNDRIVEN_INPUT_PULL_SEL(pl));
  lcc_partner lcc_partner_inst (.clock(clock), .go(go), .delay(dly), .start(st), .done(dn));
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input [31:0] s, input [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic wreg(input [7:0] a, input [7:0] d);
    {addr, wd, wr} <= {a, d, 1'h1};
    tick(1);
    wr <= 0;
    tick(2);
  endtask
  task automatic rreg(input [7:0] a, input [7:0] e);
    addr <= a;
    tick(2);
    chk(rd, e);
  endtask
  task automatic pulse(input int n, input logic e);
    logic seen;
    logic seen_f;
    seen = 0;
    seen_f = 0;
    sy <= 1;
    tick(n);
    sy <= 0;
    repeat (10) begin
      tick(1);
      seen |= ls;
      seen_f |= fso;
    end
    chk({seen, seen_f}, {e, e});
  endtask
  task automatic xact(input [7:0] d, input logic e);
    int n;
    n = 0;
    {go, dly} <= {1'h1, d};
    tick(1);
    go <= 0;
    while (ab !== 1'h1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(n > 9 && n < 15, e);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rreg(8'h03, 8'hf0);
    rreg(8'h04, 8'hfe);
    chk({cg, pl}, 2'h3);
    wreg(8'h03, 8'h08);
    wreg(8'h05, 8'hff);
    rreg(8'h05, 8'h00);
    rreg(8'h03, 8'h08);
    {mt, iw} <= 2'h3;
    tick(2);
    chk({cg, pl, fw, ak}, 4'h2);
    wreg(8'h03, 8'h04);
    chk({fw, ak}, 2'h1);
    lk <= 1;
    wreg(8'h03, 8'h00);
    chk({fw, ak}, 2'h1);
    $display("registers done");
  endtask
  task automatic t_gate;
    pix <= 24'ha5_a5a5;
    tick(3);
    chk(po, 24'ha5_a5a5);
    wreg(8'h03, 8'h02);
    chk(po, 24'h0);
    wreg(8'h03, 8'h00);
    prot <= 1;
    tick(3);
    chk(po, 24'h0);
    dv <= 1;
    tick(4);
    chk({dvo, po}, {1'h1, 24'ha5_a5a5});
    dv <= 0;
    $display("gating done");
  endtask
  task automatic t_filt;
    wreg(8'h03, 8'h10);
    pulse(1, 0);
    pulse(2, 1);
    two <= 1;
    pulse(3, 0);
    pulse(4, 1);
    $display("filter done");
  endtask
  task automatic t_wdog;
    wreg(8'h04, 8'h02);
    xact(0, 1);
    xact(3, 0);
    wreg(8'h04, 8'h03);
    xact(0, 0);
    $display("watchdog done");
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    tick(2);
    rst_n <= 1;
    tick(1);
    t_regs;
    t_gate;
    t_filt;
    t_wdog;
    stop_test;
  end
  initial begin
    tick(2000);
    err_count++;
    stop_test;
  end
endmodule
